// ==== core/xcfg_pkg.sv ====
// package: constants, register map and types of the crosspoint config host
// How it works
// R1 - bank zero data selects source for output
// R2 - data 100001 selects source port last
// R3 - address 100001 selects dest port last
// R4 - output index all ones broadcasts
// R5 - all ones source code disables output
// R6 - bank one low four bits current code
// R7 - broadcast current code sets every output
// R8 - reset low disables outputs, code 0111
// R9 - port select high leaves device idle
// R10 - select, write low, read high stores latch
// R11 - select and read low drives readback
// R12 - select and update low copies ranks
// R13 - write plus update low is transparent
// R14 - write strobe low at least 10 ns
// R15 - update strobe low at least 10 ns
// R16 - outputs settle within 45 ns of update
// R17 - transparent reprogram 45 ns, enable 50
// R18 - readback data valid within 30 ns
// R19 - reset held low at least 10 ns
// R20 - outputs disable no sooner than 10 ns
// R21 - second rank holds until update or reset
package xcfg_pkg;
  // ----------------------------------------
  // clock and timing
  // ----------------------------------------
  localparam int unsigned clk_period_ns = 10;
  localparam int unsigned write_pulse_width_ns = 10;
  localparam int unsigned update_pulse_width_ns = 10;
  localparam int unsigned reset_pulse_width_ns = 10;
  localparam int unsigned readback_access_time_ns = 30;
  localparam int unsigned update_settle_ns = 45;
  localparam int unsigned transp_enable_ns = 50;
  localparam int unsigned reset_disable_ns = 25;
  // least times round up, whole cycles
  localparam int unsigned write_cyc =
    (write_pulse_width_ns + clk_period_ns - 1) / clk_period_ns;
  localparam int unsigned update_cyc =
    (update_pulse_width_ns + clk_period_ns - 1) / clk_period_ns;
  localparam int unsigned reset_cyc =
    (reset_pulse_width_ns + clk_period_ns - 1) / clk_period_ns;
  // waits for the device: round up so data is surely there
  localparam int unsigned read_cyc =
    (readback_access_time_ns + clk_period_ns - 1) / clk_period_ns;
  localparam int unsigned settle_cyc =
    (transp_enable_ns + clk_period_ns - 1) / clk_period_ns;
  localparam int unsigned reset_settle_cyc =
    (reset_disable_ns + clk_period_ns - 1) / clk_period_ns;
  localparam int unsigned cnt_w = 4;
  // data pins pass this many flops before the sequencer reads them
  localparam int unsigned sync_stages = 2;

  // ----------------------------------------
  // device field layout
  // ----------------------------------------
  localparam logic [5:0] output_index_bcast = 6'h3f;
  localparam logic [5:0] output_index_last = 6'h21;
  localparam logic [5:0] source_port_last = 6'h21;
  localparam logic [5:0] source_disable = 6'h3f;
  localparam logic [3:0] current_code_reset = 4'h7;
  localparam logic bank_connection = 1'b0;
  localparam logic bank_current = 1'b1;

  // ----------------------------------------
  // host register map (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] reg_cmd = 8'h00;
  localparam logic [7:0] reg_status = 8'h04;
  localparam logic [7:0] reg_rdata = 8'h08;
  // command word fields
  localparam int unsigned cmd_data_lsb = 0;
  localparam int unsigned cmd_addr_lsb = 8;
  localparam int unsigned cmd_op_lsb = 16;
  localparam int unsigned status_busy_bit = 0;
  localparam int unsigned status_err_bit = 1;
  localparam logic [1:0] axi_okay = 2'h0;
  localparam logic [1:0] axi_slverr = 2'h2;

  // operation codes written into the command register
  typedef enum logic [2:0] {
    xcfg_op_write = 3'h0,
    xcfg_op_update = 3'h1,
    xcfg_op_transp = 3'h2,
    xcfg_op_read = 3'h3,
    xcfg_op_reset = 3'h4
  } xcfg_op_t;

  // one command handed from the register file to the sequencer
  typedef struct packed {
    xcfg_op_t op;
    logic [6:0] addr;
    logic [5:0] data;
  } xcfg_cmd_t;

  // pins toward the device
  typedef struct packed {
    logic reset_n;
    logic port_select_n;
    logic write_strobe_n;
    logic read_strobe_n;
    logic update_strobe_n;
    logic [6:0] addr;
    logic [5:0] data_out;
    logic data_oe;
  } xcfg_pins_t;
endpackage

// ==== core/xcfg_seq.sv ====
// pin sequencer: turns one command into a strobe cycle on the device pins
`timescale 1ns/100ps
module xcfg_seq
  import xcfg_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire xcfg_cmd_t cmd,
  input wire logic [5:0] data_in,
  output xcfg_pins_t pins,
  output logic done,
  output logic [5:0] rdata
);
  typedef enum logic [2:0] {
    s_idle, s_strobe, s_settle, s_done
  } xcfg_seq_st_t;

  // all state of the sequencer
  typedef struct packed {
    xcfg_seq_st_t st;
    logic [cnt_w-1:0] cnt;
    xcfg_cmd_t cmd;
    xcfg_pins_t pins;
    logic [5:0] rdata;
    logic [5:0] sync1;
    logic [5:0] sync2;
    logic done;
  } xcfg_seq_state_t;

  xcfg_seq_state_t s_q, s_d;

  // idle pin levels: device deselected, strobes high, bus released
  function automatic xcfg_pins_t idle_pins();
    xcfg_pins_t p;
    p = '0;
    p.reset_n = 1'b1;
    p.port_select_n = 1'b1; // R9
    p.write_strobe_n = 1'b1;
    p.read_strobe_n = 1'b1;
    p.update_strobe_n = 1'b1;
    return p;
  endfunction

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb
  begin
    s_d = s_q;
    s_d.done = 1'b0;
    // data pins pass two flops before use
    s_d.sync1 = data_in;
    s_d.sync2 = s_q.sync1;
    case (s_q.st)
      s_idle:
      begin
        if (cmd_valid)
        begin
          s_d.cmd = cmd;
          s_d.st = s_strobe;
          s_d.pins = idle_pins();
          s_d.pins.addr = cmd.addr; // R1 R3
          case (cmd.op)
            xcfg_op_write:
            begin
              // select low, write low, read high: first rank
              s_d.pins.port_select_n = 1'b0; // R10
              s_d.pins.write_strobe_n = 1'b0; // R10
              s_d.pins.data_out = cmd.data; // R1 R2 R5 R6
              s_d.pins.data_oe = 1'b1;
              s_d.cnt = cnt_w'(write_cyc); // R14
            end
            xcfg_op_update:
            begin
              s_d.pins.port_select_n = 1'b0;
              s_d.pins.update_strobe_n = 1'b0; // R12
              s_d.cnt = cnt_w'(update_cyc); // R15
            end
            xcfg_op_transp:
            begin
              // read stays high as the gate; write and update low
              s_d.pins.port_select_n = 1'b0;
              s_d.pins.write_strobe_n = 1'b0; // R13
              s_d.pins.update_strobe_n = 1'b0; // R13
              s_d.pins.data_out = cmd.data;
              s_d.pins.data_oe = 1'b1;
              s_d.cnt = cnt_w'(update_cyc); // R15
            end
            xcfg_op_read:
            begin
              // bus released before the device may drive it
              s_d.pins.port_select_n = 1'b0;
              s_d.pins.read_strobe_n = 1'b0; // R11
              // access time plus two synchroniser stages
              s_d.cnt = cnt_w'(read_cyc + sync_stages); // R18
            end
            xcfg_op_reset:
            begin
              s_d.pins.reset_n = 1'b0; // R8
              s_d.cnt = cnt_w'(reset_cyc); // R19
            end
            default:
            begin
              s_d.st = s_idle;
            end
          endcase
        end
      end
      s_strobe:
      begin
        if (s_q.cnt > cnt_w'(1))
          s_d.cnt = s_q.cnt - cnt_w'(1);
        else
        begin
          // capture readback on the same edge that releases read strobe
          if (s_q.cmd.op == xcfg_op_read)
            s_d.rdata = s_q.sync2; // R11
          s_d.pins = idle_pins();
          // keep address past the strobes, until the next command, for hold
          s_d.pins.addr = s_q.pins.addr;
          s_d.st = s_settle;
          case (s_q.cmd.op)
            xcfg_op_update: s_d.cnt = cnt_w'(settle_cyc); // R16
            xcfg_op_transp: s_d.cnt = cnt_w'(settle_cyc); // R17
            xcfg_op_reset: s_d.cnt = cnt_w'(reset_settle_cyc); // R20
            default: s_d.cnt = cnt_w'(1);
          endcase
        end
      end
      s_settle:
      begin
        // device outputs settle before the next command goes out
        if (s_q.cnt > cnt_w'(1))
          s_d.cnt = s_q.cnt - cnt_w'(1);
        else
          s_d.st = s_done;
      end
      s_done:
      begin
        s_d.done = 1'b1;
        s_d.st = s_idle;
      end
      default:
      begin
        s_d.st = s_idle;
      end
    endcase
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_q <= '0;
      s_q.pins.reset_n <= 1'b1;
      s_q.pins.port_select_n <= 1'b1;
      s_q.pins.write_strobe_n <= 1'b1;
      s_q.pins.read_strobe_n <= 1'b1;
      s_q.pins.update_strobe_n <= 1'b1;
    end
    else
      s_q <= s_d;
  end

  assign cmd_ready = (s_q.st == s_idle);
  assign pins = s_q.pins;
  assign done = s_q.done;
  assign rdata = s_q.rdata;
endmodule

// ==== core/xcfg_host.sv ====
// crosspoint config host: axi4-lite registers driving the device pins
//
// Implementation choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/100ps
module xcfg_host
  import xcfg_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // device pins
  output logic dev_reset_n,
  output logic port_select_n,
  output logic write_strobe_n,
  output logic read_strobe_n,
  output logic update_strobe_n,
  output logic [6:0] dev_addr,
  input wire logic [5:0] dev_data_i,
  output logic [5:0] dev_data_o,
  output logic dev_data_oe
);
  // all state of the register file
  typedef struct packed {
    logic aw_seen;
    logic [7:0] awaddr;
    logic w_seen;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic pend;
    xcfg_cmd_t cmd;
    logic err;
  } xcfg_host_state_t;

  xcfg_host_state_t h_q, h_d;
  logic seq_ready; // sequencer can take a command
  logic [5:0] seq_rdata; // last readback value
  xcfg_pins_t pins; // pin bundle from the sequencer
  logic wr_fire; // both write halves present
  logic busy; // command pending or in flight

  // ----------------------------------------
  // pin sequencer
  // ----------------------------------------
  xcfg_seq u_seq (
    .clock(clock),
    .rst_n(rst_n),
    .cmd_valid(h_q.pend),
    .cmd_ready(seq_ready),
    .cmd(h_q.cmd),
    .data_in(dev_data_i),
    .pins(pins),
    .done(),
    .rdata(seq_rdata)
  );

  assign busy = h_q.pend || !seq_ready;
  assign wr_fire = h_q.aw_seen && h_q.w_seen && !h_q.bvalid;

  // ----------------------------------------
  // bus and command logic
  // ----------------------------------------
  always_comb
  begin
    h_d = h_q;
    // address and data taken in either order, held until response
    if (s_axi_awvalid && s_axi_awready)
    begin
      h_d.aw_seen = 1'b1;
      h_d.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      h_d.w_seen = 1'b1;
      h_d.wdata = s_axi_wdata;
      h_d.wstrb = s_axi_wstrb;
    end
    // sequencer took the command
    if (h_q.pend && seq_ready)
      h_d.pend = 1'b0;
    if (wr_fire)
    begin
      h_d.aw_seen = 1'b0;
      h_d.w_seen = 1'b0;
      h_d.bvalid = 1'b1;
      h_d.bresp = axi_okay;
      if (h_q.awaddr == reg_cmd)
      begin
        // a command while busy is refused, never queued over
        if (busy || h_q.wstrb[2:0] != 3'h7)
        begin
          h_d.bresp = axi_slverr;
          h_d.err = 1'b1;
        end
        else
        begin
          h_d.cmd.data = h_q.wdata[cmd_data_lsb +: 6];
          h_d.cmd.addr = h_q.wdata[cmd_addr_lsb +: 7];
          h_d.cmd.op = xcfg_op_t'(h_q.wdata[cmd_op_lsb +: 3]);
          h_d.pend = 1'b1;
        end
      end
      else if (h_q.awaddr == reg_status)
      begin
        // writing one clears the sticky error flag
        if (h_q.wstrb[0] && h_q.wdata[status_err_bit])
          h_d.err = 1'b0;
      end
      else
        h_d.bresp = axi_slverr;
    end
    if (h_q.bvalid && s_axi_bready)
      h_d.bvalid = 1'b0;
    // reads answer one cycle after the address is taken
    if (s_axi_arvalid && s_axi_arready)
    begin
      h_d.rvalid = 1'b1;
      h_d.rresp = axi_okay;
      h_d.rdata = '0;
      case (s_axi_araddr)
        reg_cmd: h_d.rdata = 32'(h_q.cmd);
        reg_status:
        begin
          h_d.rdata[status_busy_bit] = busy;
          h_d.rdata[status_err_bit] = h_q.err;
        end
        reg_rdata: h_d.rdata = 32'(seq_rdata);
        default: h_d.rresp = axi_slverr;
      endcase
    end
    if (h_q.rvalid && s_axi_rready)
      h_d.rvalid = 1'b0;
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      h_q <= '0;
    else
      h_q <= h_d;
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign s_axi_awready = !h_q.aw_seen && !h_q.bvalid;
  assign s_axi_wready = !h_q.w_seen && !h_q.bvalid;
  assign s_axi_bvalid = h_q.bvalid;
  assign s_axi_bresp = h_q.bresp;
  assign s_axi_arready = !h_q.rvalid;
  assign s_axi_rvalid = h_q.rvalid;
  assign s_axi_rdata = h_q.rdata;
  assign s_axi_rresp = h_q.rresp;
  assign dev_reset_n = pins.reset_n;
  assign port_select_n = pins.port_select_n;
  assign write_strobe_n = pins.write_strobe_n;
  assign read_strobe_n = pins.read_strobe_n;
  assign update_strobe_n = pins.update_strobe_n;
  assign dev_addr = pins.addr;
  assign dev_data_o = pins.data_out;
  assign dev_data_oe = pins.data_oe;
endmodule

// ==== verification/xcfg_chk.sv ====
// checker: pin-level assertions on the crosspoint config host
`timescale 1ns/100ps
module xcfg_chk
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic dev_reset_n,
  input wire logic port_select_n,
  input wire logic write_strobe_n,
  input wire logic read_strobe_n,
  input wire logic update_strobe_n,
  input wire logic [6:0] dev_addr,
  input wire logic dev_data_oe
);
  // ----------------------------------------
  // strobe relations, all on the one clock
  // ----------------------------------------
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  a_idle_quiet: assert property (
    port_select_n |-> write_strobe_n && read_strobe_n &&
    update_strobe_n && !dev_data_oe) else $error("strobe while idle");
  a_write_gate: assert property (
    !write_strobe_n |-> !port_select_n && read_strobe_n && dev_data_oe)
    else $error("bad write strobe");
  a_read_float: assert property (
    !read_strobe_n |-> !port_select_n && !dev_data_oe)
    else $error("host drives during read");
  a_transp_gate: assert property (
    !write_strobe_n && !update_strobe_n |-> read_strobe_n ##1
    (write_strobe_n && update_strobe_n)) else $error("bad transparent");
  a_write_width: assert property (
    $fell(write_strobe_n) |=> write_strobe_n && $stable(dev_addr))
    else $error("write pulse or address hold");
  a_upd_width: assert property (
    $fell(update_strobe_n) |-> !port_select_n ##1 update_strobe_n)
    else $error("update pulse");
  a_upd_settle: assert property (
    $rose(update_strobe_n) |-> port_select_n[*4])
    else $error("no settle after update");
  a_read_hold: assert property (
    $fell(read_strobe_n) |-> (!read_strobe_n && !port_select_n)[*5]
    ##1 read_strobe_n) else $error("read access too short");
  a_reset_width: assert property (
    $fell(dev_reset_n) |=> (dev_reset_n && port_select_n)[*3])
    else $error("device reset pulse");
endmodule
bind xcfg_host xcfg_chk u_chk (.clock(clock), .rst_n(rst_n),
  .dev_reset_n(dev_reset_n), .port_select_n(port_select_n),
  .write_strobe_n(write_strobe_n), .read_strobe_n(read_strobe_n),
  .update_strobe_n(update_strobe_n), .dev_addr(dev_addr),
  .dev_data_oe(dev_data_oe));

// ==== verification/xcfg_dev_model.sv ====
// device model: two-rank crosspoint latches behind the parallel port
`timescale 1ns/100ps
module xcfg_dev_model
(
  input wire logic reset_n,
  input wire logic port_select_n,
  input wire logic write_strobe_n,
  input wire logic read_strobe_n,
  input wire logic update_strobe_n,
  input wire logic [6:0] addr,
  input wire logic [5:0] data_in,
  output logic [5:0] data_out = 6'h2a
);
  logic [5:0] fr_src[34], sr_src[34]; // routing, first and second rank
  logic [3:0] fr_cur[34], sr_cur[34]; // drive current codes
  // ----------------------------------------
  // latch behaviour
  // ----------------------------------------
  // global reset acts late, never sooner than 10 ns
  always @(negedge reset_n)
  begin
    #10;
    foreach (sr_src[i])
    begin
      fr_src[i] = 6'h3f;
      sr_src[i] = 6'h3f;
      fr_cur[i] = 4'h7;
      sr_cur[i] = 4'h7;
    end
  end
  // first rank write; index all ones reaches every output
  always @(negedge write_strobe_n)
  begin
    #1;
    if (reset_n && !port_select_n && read_strobe_n)
      foreach (fr_src[i])
        if (addr[5:0] == 6'(i) || addr[5:0] == 6'h3f)
        begin
          if (addr[6])
            fr_cur[i] = data_in[3:0];
          else
            fr_src[i] = data_in;
        end
  end
  // second rank moves here or on global reset; here it moves after any transparent write
  always @(negedge update_strobe_n)
  begin
    #2;
    if (reset_n && !port_select_n)
    begin
      sr_src = fr_src;
      sr_cur = fr_cur;
    end
  end
  // readback is slow; released pins show the inverse, not a held value
  always @(port_select_n or read_strobe_n or addr)
    if (reset_n && !port_select_n && !read_strobe_n)
      data_out <= #25 (addr[5:0] > 6'h21) ? 6'h00 :
        addr[6] ? {2'b00, sr_cur[addr[5:0]]} : sr_src[addr[5:0]];
    else
      data_out <= #25 ~data_out;
endmodule

// ==== verification/tb.sv ====
// testbench: axi4-lite command sequences against the device model
`timescale 1ns/100ps
module tb
  import xcfg_pkg::*;
;
  logic clock, rst_n, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, v;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  logic dreset_n, ps_n, wr_n, rd_n, up_n, oe;
  logic [6:0] daddr;
  logic [5:0] d_o, d_i;
  int fail_count, comparisons;
  xcfg_host u_dut (.clock(clock), .rst_n(rst_n), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .dev_reset_n(dreset_n),
    .port_select_n(ps_n), .write_strobe_n(wr_n), .read_strobe_n(rd_n),
    .update_strobe_n(up_n), .dev_addr(daddr), .dev_data_i(d_i),
    .dev_data_o(d_o), .dev_data_oe(oe));
  xcfg_dev_model u_dev (.reset_n(dreset_n), .port_select_n(ps_n),
    .write_strobe_n(wr_n), .read_strobe_n(rd_n), .update_strobe_n(up_n),
    .addr(daddr), .data_in(d_o), .data_out(d_i));
  // ----------------------------------------
  // clock and watchdog
  // ----------------------------------------
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // a hung handshake ends here; the run needs well under 5000 cycles
  initial
  begin
    repeat (20000) @(posedge clock);
    fail_count++;
    give_verdict();
  end
  // ----------------------------------------
  // bus tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e)
    begin
      fail_count++;
      $display("Error %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // write: address and data offered together, each dropped when taken
  task automatic axw(input logic [7:0] a, input logic [31:0] d,
    input logic [3:0] s, output logic [1:0] resp);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clock);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
    @(posedge clock);
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] d,
    output logic [1:0] resp);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clock);
      if (arready)
        arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    resp = rresp;
    rready <= 1'b0;
    @(posedge clock);
  endtask
  // one command, then poll busy; status must not flag an error
  task automatic cmd(input xcfg_op_t op, input logic [6:0] a,
    input logic [5:0] d);
    axw(reg_cmd, {13'h0, op, 1'b0, a, 2'b0, d}, 4'hf, r);
    chk(32'(r), 32'(axi_okay));
    do axr(reg_status, v, r); while (v[status_busy_bit] !== 1'b0);
    chk(v & 32'h3, 32'h0);
  endtask
  task automatic rb(input logic [6:0] a, input logic [5:0] e);
    cmd(xcfg_op_read, a, 6'h00);
    axr(reg_rdata, v, r);
    chk(v, {26'h0, e});
  endtask
  task automatic give_verdict;
    $display("comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial
  begin
    {rst_n, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, wstrb} = '0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    cmd(xcfg_op_reset, 7'h00, 6'h00);
    cmd(xcfg_op_write, 7'h00, 6'h21);
    cmd(xcfg_op_write, 7'h21, 6'h1f);
    rb(7'h00, 6'h3f);
    cmd(xcfg_op_update, 7'h00, 6'h00);
    rb(7'h00, 6'h21);
    rb(7'h21, 6'h1f);
    cmd(xcfg_op_write, 7'h40, 6'h3f);
    cmd(xcfg_op_update, 7'h00, 6'h00);
    rb(7'h40, 6'h0f);
    cmd(xcfg_op_transp, 7'h7f, 6'h08);
    rb(7'h40, 6'h08);
    rb(7'h61, 6'h08);
    // the command register reads back as the packed last command
    axr(reg_cmd, v, r);
    chk(v, {16'h0, xcfg_op_read, 7'h61, 6'h00});
    cmd(xcfg_op_write, 7'h3f, 6'h00);
    cmd(xcfg_op_update, 7'h00, 6'h00);
    rb(7'h0a, 6'h00);
    cmd(xcfg_op_transp, 7'h3f, 6'h3f);
    rb(7'h21, 6'h3f);
    cmd(xcfg_op_transp, 7'h00, 6'h05);
    rb(7'h00, 6'h05);
    // a partial strobe, or a command while busy, is refused
    axw(reg_cmd, 32'h0, 4'h1, r);
    chk(32'(r), 32'(axi_slverr));
    axw(reg_cmd, {13'h0, xcfg_op_update, 16'h0}, 4'hf, r);
    chk(32'(r), 32'(axi_okay));
    axw(reg_cmd, {13'h0, xcfg_op_update, 16'h0}, 4'hf, r);
    chk(32'(r), 32'(axi_slverr));
    do axr(reg_status, v, r); while (v[status_busy_bit] !== 1'b0);
    chk(v & 32'h2, 32'h2);
    axw(reg_status, 32'h2, 4'hf, r);
    chk(32'(r), 32'(axi_okay));
    axr(reg_status, v, r);
    chk(v & 32'h3, 32'h0);
    axr(8'h0c, v, r);
    chk({v[29:0], r}, {30'h0, axi_slverr});
    // an unknown operation is dropped and leaves no error
    cmd(xcfg_op_t'(3'h5), 7'h00, 6'h00);
    cmd(xcfg_op_reset, 7'h00, 6'h00);
    rb(7'h00, 6'h3f);
    rb(7'h40, 6'h07);
    give_verdict();
  end
endmodule
